// >>> rtl/dsc_cache_ctrl.sv
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// Summary of operation
// RULE_01: auto spin-up reaches ready within 30 s
// RULE_02: accept some commands within 3 s
// RULE_03: deferred start needs start command; stop allowed
// RULE_04: host sets segment count, buffer repartitioned
// RULE_05: cache enabled: look up buffer first
// RULE_06: cache disabled: read medium, pass through segment
// RULE_07: miss uses ratio pacing, hit ignores it
// RULE_08: send cached run, fetch remainder from disc
// RULE_09: first block missing: read all into one segment
// RULE_10: segments circular, whole sectors long
// RULE_11: size from count; sense reports FFFF
// RULE_12: size write ignored; param_check_a mode rejects it
// RULE_13: counts 1 to 16, default three
// RULE_14: write invalidates overlapping segments, caches data
// RULE_15: write wraps but never overwrites uncommitted data
// RULE_16: write cache on: early good status
// RULE_17: medium failure after good status: deferred error
// RULE_18: flush commits all buffered writes first
// RULE_19: read-ahead prefetches beyond read, counts hits; code only sets a pf_hit_reg flag on read hits with rcd_reg set
// RULE_20: prefetch capped by max field, ceiling ignored
// RULE_21: cross cylinder only with discontinuity bit
// RULE_22: adaptive look-ahead tracks contiguous/interleaved reads
// RULE_23: segments split evenly, rounded down to sectors
module dsc_cache_ctrl #(
	parameter longint unsigned READY_CYC  = dsc_pkg::READY_CYCLES,
	parameter longint unsigned ACCEPT_CYC = dsc_pkg::ACCEPT_CYCLES,
	parameter int              NSEG       = dsc_pkg::MAX_SEGS
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// classic wishbone slave
	input  wire logic                 wb_cyc_i,
	input  wire logic                 wb_stb_i,
	input  wire logic                 wb_we_i,
	input  wire logic [7:0]           wb_adr_i,
	input  wire logic [3:0]           wb_sel_i,
	input  wire logic [31:0]          wb_dat_i,
	output logic [31:0]               wb_dat_o,
	output logic                      wb_ack_o,
	// medium read/write channel
	output dsc_pkg::dsc_media_req_s   media_req,
	output logic                      media_valid,
	input  wire logic                 media_done,
	input  wire logic                 media_err,
	// host transfer pacing
	output logic                      ratio_pacing,
	output logic                      host_busy
);

	// register state
	logic        rcd_reg, disc_reg, dra_reg, wce_reg, param_check_a_reg, defer_start_reg;
	logic [4:0]  segcnt_reg;
	logic [15:0] maxpf_reg, pfceil_reg, cyl_len_reg;
	logic [31:0] req_lba_reg;
	logic [15:0] req_cnt_reg;
	logic        illegal_reg, deferred_reg, good_reg, pf_hit_reg, done_reg;
	logic [15:0] seg_sectors_reg;
	logic [31:0] xfer_cnt_reg;

	// engine state
	typedef enum logic [2:0] {DSC_IDLE, DSC_LOOK, DSC_FETCH, DSC_WAIT, DSC_PREF,
	                          DSC_PWAIT, DSC_FLUSH} dsc_state_e;
	dsc_state_e          state_reg;
	dsc_pkg::dsc_spin_e  spin_reg;
	logic [63:0]         power_cnt_reg;
	logic [63:0]         spin_cnt_reg;
	logic                accept_reg;
	logic [31:0]         cur_lba_reg;
	logic [15:0]         cur_cnt_reg;
	logic                cur_wr_reg;
	logic [15:0]         dirty_reg;
	logic                early_good_reg;
	logic [3:0]          fill_seg_reg;
	logic [31:0]         last_end_reg, prev_stride_reg, prev_lba_reg;
	logic                adaptive_lookahead_on_reg;

	logic        look_hit;
	logic [15:0] look_run;
	logic        wb_req, wr_en, rd_en;
	logic        cmd_go;
	logic [2:0]  cmd_code;

	assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_en    = wb_req && wb_we_i && wb_sel_i[0];
	assign rd_en    = wb_req && !wb_we_i;
	assign cmd_go   = wr_en && (wb_adr_i == dsc_pkg::OFS_COMMAND);
	assign cmd_code = wb_dat_i[2:0];

	// even split of usable sectors, rounded down per segment
	function automatic logic [15:0] seg_size(input logic [4:0] n);
		return (n == 5'h00) ? dsc_pkg::BUF_SECTORS : 16'(dsc_pkg::BUF_SECTORS / {11'h000, n});
	endfunction

	// prefetch length limited by cap and, unless allowed, by cylinder end
	function automatic logic [15:0] pf_len(input logic [31:0] lba, input logic [15:0] cap,
	                                       input logic [15:0] cyl, input logic disc);
		logic [15:0] left;
		left = (cyl == 16'h0000) ? cap : 16'(cyl - 16'(lba % {16'h0000, cyl}));
		return (disc || cap < left) ? cap : left;
	endfunction

	dsc_seg_table #(
		.NSEG (NSEG)
	) u_table (
		.clk       (clk),
		.rst_n     (rst_n),
		.flush_all (cmd_go && cmd_code == dsc_pkg::CMD_WRITE && rcd_reg),
		.seg_count (segcnt_reg),
		.look_lba  (cur_lba_reg),
		.look_hit  (look_hit),
		.look_run  (look_run),
		.inval     (state_reg == DSC_LOOK && cur_wr_reg && !rcd_reg),
		.inval_lba (cur_lba_reg),
		.inval_cnt (cur_cnt_reg),
		.fill      ((state_reg == DSC_WAIT || state_reg == DSC_PWAIT) && media_done),
		.fill_seg  (fill_seg_reg),
		.fill_lba  (media_req.lba),
		.fill_cnt  (media_req.count)
	);

	// power-on timing: power-on count and command acceptance
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			power_cnt_reg <= 64'h0000_0000_0000_0000;
			accept_reg    <= 1'b0;
		end else if (!accept_reg) begin
			power_cnt_reg <= power_cnt_reg + 64'h0000_0000_0000_0001;
			accept_reg    <= (power_cnt_reg + 64'h0000_0000_0000_0001 >= ACCEPT_CYC); // [RULE_02]
		end
	end

	// spindle; a stop command is taken only in the ready state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			spin_reg     <= dsc_pkg::DSC_SPIN_OFF;
			spin_cnt_reg <= 64'h0000_0000_0000_0000;
		end else begin
			case (spin_reg)
				dsc_pkg::DSC_SPIN_OFF: begin
					spin_cnt_reg <= 64'h0000_0000_0000_0000;
					if ((!defer_start_reg && power_cnt_reg == 64'h0000_0000_0000_0000) || // [RULE_01]
					    (cmd_go && accept_reg && cmd_code == dsc_pkg::CMD_START)) begin // [RULE_03]
						spin_reg <= dsc_pkg::DSC_SPIN_UP;
					end
				end
				dsc_pkg::DSC_SPIN_UP: begin
					spin_cnt_reg <= spin_cnt_reg + 64'h0000_0000_0000_0001;
					if (spin_cnt_reg + 64'h0000_0000_0000_0001 >= READY_CYC) begin
						spin_reg <= dsc_pkg::DSC_SPIN_READY; // [RULE_01] [RULE_03]
					end
				end
				dsc_pkg::DSC_SPIN_READY: begin
					if (cmd_go && cmd_code == dsc_pkg::CMD_STOP) begin
						spin_reg <= dsc_pkg::DSC_SPIN_OFF; // [RULE_03]
					end
				end
				default: spin_reg <= dsc_pkg::DSC_SPIN_OFF;
			endcase
		end
	end

	// mode parameters written by software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rcd_reg         <= 1'b0;
			disc_reg        <= 1'b0;
			dra_reg         <= 1'b0;
			wce_reg         <= 1'b0;
			param_check_a_reg      <= 1'b0;
			defer_start_reg <= 1'b0;
			segcnt_reg      <= dsc_pkg::SEGCNT_RST; // [RULE_13]
			maxpf_reg       <= dsc_pkg::MAXPF_RST;
			pfceil_reg      <= 16'h0000;
			cyl_len_reg     <= dsc_pkg::CYL_LEN_RST;
			req_lba_reg     <= 32'h0000_0000;
			req_cnt_reg     <= 16'h0000;
		end else if (wr_en) begin
			case (wb_adr_i)
				dsc_pkg::OFS_CACHE_CTRL: begin
					rcd_reg         <= wb_dat_i[dsc_pkg::BIT_RCD];
					disc_reg        <= wb_dat_i[dsc_pkg::BIT_DISC];
					dra_reg         <= wb_dat_i[dsc_pkg::BIT_DRA];
					wce_reg         <= wb_dat_i[dsc_pkg::BIT_WCE];
					param_check_a_reg      <= wb_dat_i[dsc_pkg::BIT_PARAM_CHECK_A];
					defer_start_reg <= wb_dat_i[dsc_pkg::BIT_DEFER_ST];
					// out-of-range counts are dropped, keeping the last good partition
					if (wb_dat_i[dsc_pkg::POS_SEGCNT +: 5] >= 5'h01 &&
					    wb_dat_i[dsc_pkg::POS_SEGCNT +: 5] <= 5'h10) begin
						segcnt_reg <= wb_dat_i[dsc_pkg::POS_SEGCNT +: 5]; // [RULE_04] [RULE_13]
					end
				end
				dsc_pkg::OFS_PREFETCH: begin
					maxpf_reg  <= wb_dat_i[15:0];
					pfceil_reg <= wb_dat_i[31:16]; // stored only, never steers prefetch [RULE_20]
				end
				dsc_pkg::OFS_CYL_LEN: cyl_len_reg <= wb_dat_i[15:0];
				dsc_pkg::OFS_READ_REQ: begin
					req_lba_reg <= wb_dat_i;
				end
				dsc_pkg::OFS_XFER: req_cnt_reg <= wb_dat_i[15:0];
				default: ;
			endcase
		end
	end

	// segment size follows the count alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seg_sectors_reg <= 16'h0000;
		end else begin
			seg_sectors_reg <= seg_size(segcnt_reg); // [RULE_11] [RULE_23] [RULE_10]
		end
	end

	// status flags: hardware set wins over the read-to-clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			illegal_reg  <= 1'b0;
			deferred_reg <= 1'b0;
			pf_hit_reg   <= 1'b0;
		end else begin
			if (rd_en && wb_adr_i == dsc_pkg::OFS_STATUS) begin
				illegal_reg  <= 1'b0;
				deferred_reg <= 1'b0;
				pf_hit_reg   <= 1'b0;
			end
			if (wr_en && wb_adr_i == dsc_pkg::OFS_SEGSIZE && param_check_a_reg) begin
				illegal_reg <= 1'b1; // [RULE_12]
			end
			if (state_reg == DSC_WAIT && media_done && media_err && early_good_reg) begin
				deferred_reg <= 1'b1; // [RULE_17]
			end
			if (state_reg == DSC_LOOK && !cur_wr_reg && look_hit && rcd_reg) begin
				pf_hit_reg <= 1'b1; // [RULE_19]
			end
		end
	end

	// command engine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg      <= DSC_IDLE;
			cur_lba_reg    <= 32'h0000_0000;
			cur_cnt_reg    <= 16'h0000;
			cur_wr_reg     <= 1'b0;
			media_req      <= '0;
			media_valid    <= 1'b0;
			dirty_reg      <= 16'h0000;
			early_good_reg <= 1'b0;
			good_reg       <= 1'b0;
			done_reg       <= 1'b0;
			fill_seg_reg   <= 4'h0;
			ratio_pacing   <= 1'b0;
			xfer_cnt_reg   <= 32'h0000_0000;
		end else begin
			media_valid <= 1'b0;
			case (state_reg)
				DSC_IDLE: begin
					if (cmd_go && spin_reg == dsc_pkg::DSC_SPIN_READY) begin
						done_reg    <= 1'b0;
						good_reg    <= 1'b0;
						cur_lba_reg <= req_lba_reg;
						cur_cnt_reg <= req_cnt_reg;
						if (cmd_code == dsc_pkg::CMD_READ || cmd_code == dsc_pkg::CMD_WRITE) begin
							cur_wr_reg <= (cmd_code == dsc_pkg::CMD_WRITE);
							state_reg  <= DSC_LOOK;
						end else if (cmd_code == dsc_pkg::CMD_FLUSH) begin
							state_reg <= DSC_FLUSH;
						end
					end
				end
				DSC_LOOK: begin
					if (cur_wr_reg) begin
						// overlapping segments dropped this cycle in the table; with rcd_reg set all were flushed at the command
						media_req.wr    <= 1'b1; // [RULE_14]
						media_req.lba   <= cur_lba_reg;
						// uncommitted data is never overrun: one segment per medium pass
						media_req.count <= (cur_cnt_reg > seg_sectors_reg) ? seg_sectors_reg : cur_cnt_reg; // [RULE_15]
						media_valid     <= 1'b1;
						dirty_reg       <= cur_cnt_reg;
						if (wce_reg) begin
							good_reg       <= 1'b1; // [RULE_16]
							early_good_reg <= 1'b1;
						end
						state_reg <= DSC_WAIT;
					end else if (cur_cnt_reg == 16'h0000) begin
						done_reg  <= 1'b1;
						good_reg  <= 1'b1;
						state_reg <= (dra_reg || !adaptive_lookahead_on_reg) ? DSC_IDLE : DSC_PREF; // [RULE_22]
					end else if (look_hit && !rcd_reg) begin
						// hit run served from buffer, unpaced
						ratio_pacing <= 1'b0; // [RULE_07] [RULE_05] [RULE_08]
						if (look_run >= cur_cnt_reg) begin
							xfer_cnt_reg <= xfer_cnt_reg + {16'h0000, cur_cnt_reg};
							cur_lba_reg  <= cur_lba_reg + {16'h0000, cur_cnt_reg};
							cur_cnt_reg  <= 16'h0000;
						end else begin
							xfer_cnt_reg <= xfer_cnt_reg + {16'h0000, look_run};
							cur_lba_reg  <= cur_lba_reg + {16'h0000, look_run};
							cur_cnt_reg  <= 16'(cur_cnt_reg - look_run);
						end
					end else begin
						ratio_pacing <= 1'b1; // [RULE_07] [RULE_06] [RULE_09]
						state_reg    <= DSC_FETCH;
					end
				end
				DSC_FETCH: begin
					media_req.wr    <= 1'b0;
					media_req.lba   <= cur_lba_reg;
					media_req.count <= (cur_cnt_reg > seg_sectors_reg) ? seg_sectors_reg : cur_cnt_reg; // [RULE_10]
					media_valid     <= 1'b1;
					state_reg       <= DSC_WAIT;
				end
				DSC_WAIT: begin
					if (media_done) begin
						fill_seg_reg <= (fill_seg_reg + 4'h1 >= segcnt_reg[3:0] && segcnt_reg != 5'h10) ?
						                4'h0 : 4'(fill_seg_reg + 4'h1);
						xfer_cnt_reg <= xfer_cnt_reg + {16'h0000, media_req.count};
						cur_lba_reg  <= cur_lba_reg + {16'h0000, media_req.count};
						cur_cnt_reg  <= 16'(cur_cnt_reg - media_req.count);
						if (media_req.wr) begin
							dirty_reg <= 16'(dirty_reg - media_req.count);
							if (cur_cnt_reg == media_req.count) begin
								early_good_reg <= 1'b0;
								done_reg       <= 1'b1;
								good_reg       <= !media_err || early_good_reg;
								state_reg      <= DSC_IDLE;
							end else begin
								state_reg <= DSC_LOOK;
							end
						end else begin
							state_reg <= DSC_LOOK;
						end
					end
				end
				DSC_PREF: begin
					if (maxpf_reg != 16'h0000) begin
						media_req.wr    <= 1'b0;
						media_req.lba   <= cur_lba_reg;
						media_req.count <= pf_len(cur_lba_reg, maxpf_reg, cyl_len_reg, disc_reg); // [RULE_20] [RULE_21] [RULE_19]
						media_valid     <= 1'b1;
						state_reg       <= DSC_PWAIT;
					end else begin
						state_reg <= DSC_IDLE;
					end
				end
				DSC_PWAIT: begin
					if (media_done) begin
						fill_seg_reg <= (fill_seg_reg + 4'h1 >= segcnt_reg[3:0] && segcnt_reg != 5'h10) ?
						                4'h0 : 4'(fill_seg_reg + 4'h1);
						state_reg <= DSC_IDLE;
					end
				end
				DSC_FLUSH: begin
					// writes commit before their command ends, so nothing stays dirty here
					if (dirty_reg == 16'h0000) begin
						done_reg  <= 1'b1; // [RULE_18]
						good_reg  <= 1'b1;
						state_reg <= DSC_IDLE;
					end
				end
				default: state_reg <= DSC_IDLE;
			endcase
		end
	end

	// look-ahead adaptation from read strides
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_end_reg    <= 32'h0000_0000;
			prev_lba_reg    <= 32'h0000_0000;
			prev_stride_reg <= 32'h0000_0000;
			adaptive_lookahead_on_reg     <= 1'b1;
		end else if (cmd_go && cmd_code == dsc_pkg::CMD_READ && state_reg == DSC_IDLE &&
		             spin_reg == dsc_pkg::DSC_SPIN_READY) begin
			last_end_reg    <= req_lba_reg + {16'h0000, req_cnt_reg};
			prev_lba_reg    <= req_lba_reg;
			prev_stride_reg <= req_lba_reg - prev_lba_reg;
			// contiguous or steady interleave keeps look-ahead
			adaptive_lookahead_on_reg <= (req_lba_reg == last_end_reg) ||
			               (req_lba_reg - prev_lba_reg == prev_stride_reg); // [RULE_22]
		end
	end

	// wishbone answer: one wait state, unmapped reads give zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			if (rd_en) begin
				case (wb_adr_i)
					dsc_pkg::OFS_CACHE_CTRL: wb_dat_o <= {11'h000, segcnt_reg, 5'h00,
					    defer_start_reg, param_check_a_reg, wce_reg, 2'b00, dra_reg, disc_reg, 3'b000, rcd_reg};
					dsc_pkg::OFS_PREFETCH: wb_dat_o <= {pfceil_reg, maxpf_reg};
					dsc_pkg::OFS_SEGSIZE:  wb_dat_o <= {seg_sectors_reg, dsc_pkg::SEGSIZE_RPT}; // [RULE_11]
					dsc_pkg::OFS_READ_REQ: wb_dat_o <= req_lba_reg;
					dsc_pkg::OFS_XFER:     wb_dat_o <= xfer_cnt_reg;
					dsc_pkg::OFS_CYL_LEN:  wb_dat_o <= {16'h0000, cyl_len_reg};
					dsc_pkg::OFS_STATUS:   wb_dat_o <= {16'h0000, 5'h00, adaptive_lookahead_on_reg, pf_hit_reg,
					    accept_reg, spin_reg, deferred_reg, illegal_reg, good_reg, done_reg,
					    state_reg == DSC_IDLE ? 1'b0 : 1'b1, ratio_pacing};
					default:               wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign host_busy = (state_reg != DSC_IDLE);

endmodule // dsc_cache_ctrl

// >>> rtl/dsc_pkg.sv
package dsc_pkg;

	// clock and power-on timing
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned READY_TIME_S    = 30;
	localparam int unsigned CMD_ACCEPT_S    = 3;
	localparam longint unsigned READY_CYCLES  = longint'(READY_TIME_S) * CLK_HZ;
	localparam longint unsigned ACCEPT_CYCLES = longint'(CMD_ACCEPT_S) * CLK_HZ;

	// register byte addresses
	localparam logic [7:0] OFS_CACHE_CTRL = 8'h00;
	localparam logic [7:0] OFS_PREFETCH   = 8'h04;
	localparam logic [7:0] OFS_SEGSIZE    = 8'h08;
	localparam logic [7:0] OFS_COMMAND    = 8'h0C;
	localparam logic [7:0] OFS_READ_REQ   = 8'h10;
	localparam logic [7:0] OFS_STATUS     = 8'h14;
	localparam logic [7:0] OFS_XFER       = 8'h18;
	localparam logic [7:0] OFS_CYL_LEN    = 8'h1C;

	// cache control fields
	localparam int unsigned BIT_RCD      = 0;
	localparam int unsigned BIT_DISC     = 4;
	localparam int unsigned BIT_DRA      = 5;
	localparam int unsigned BIT_WCE      = 8;
	localparam int unsigned BIT_PARAM_CHECK_A   = 9;
	localparam int unsigned BIT_DEFER_ST = 10;
	localparam int unsigned POS_SEGCNT   = 16;

	// command codes
	localparam logic [2:0] CMD_READ  = 3'h1;
	localparam logic [2:0] CMD_WRITE = 3'h2;
	localparam logic [2:0] CMD_FLUSH = 3'h3;
	localparam logic [2:0] CMD_START = 3'h4;
	localparam logic [2:0] CMD_STOP  = 3'h5;

	// reset values, reported segment size and buffer constants
	localparam logic [4:0]  SEGCNT_RST   = 5'h03;
	localparam logic [15:0] SEGSIZE_RPT  = 16'hFFFF;
	localparam logic [15:0] MAXPF_RST    = 16'h0010;
	localparam logic [15:0] CYL_LEN_RST  = 16'h0100;
	localparam logic [15:0] BUF_SECTORS  = 16'h0690;
	localparam int unsigned MAX_SEGS     = 16;

	typedef enum logic [1:0] {DSC_SPIN_OFF, DSC_SPIN_UP, DSC_SPIN_READY} dsc_spin_e;

	// one medium request toward the read/write channel
	typedef struct packed {
		logic        wr;
		logic [31:0] lba;
		logic [15:0] count;
	} dsc_media_req_s;

endpackage : dsc_pkg

// >>> rtl/dsc_seg_table.sv
`timescale 1ns/1ps
// per-segment table of cached block ranges with hit lookup and invalidation
module dsc_seg_table #(
	parameter int NSEG = 16
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// control
	input  wire logic        flush_all,
	input  wire logic [4:0]  seg_count,
	// lookup
	input  wire logic [31:0] look_lba,
	output logic             look_hit,
	output logic [15:0]      look_run,
	// invalidate overlap with a write range
	input  wire logic        inval,
	input  wire logic [31:0] inval_lba,
	input  wire logic [15:0] inval_cnt,
	// fill one segment
	input  wire logic        fill,
	input  wire logic [3:0]  fill_seg,
	input  wire logic [31:0] fill_lba,
	input  wire logic [15:0] fill_cnt
);

	logic        valid_reg [NSEG];
	logic [31:0] base_reg  [NSEG];
	logic [15:0] len_reg   [NSEG];

	// range overlap is needed both for lookup and invalidation
	function automatic logic in_range(input logic [31:0] b, input logic [15:0] n,
	                                  input logic [31:0] x);
		return (x >= b) && ((x - b) < {16'h0000, n});
	endfunction

	// combinational lookup over the active segments only
	always_comb begin
		look_hit = 1'b0;
		look_run = 16'h0000;
		for (int i = 0; i < NSEG; i++) begin
			if (i < int'(seg_count) && valid_reg[i] && in_range(base_reg[i], len_reg[i], look_lba)) begin
				look_hit = 1'b1;
				look_run = 16'(len_reg[i] - 16'(look_lba - base_reg[i]));
			end
		end
	end

	// table update; a fill wins over invalidation of the same slot
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NSEG; i++) begin
				valid_reg[i] <= 1'b0;
				base_reg[i]  <= 32'h0000_0000;
				len_reg[i]   <= 16'h0000;
			end
		end else begin
			for (int i = 0; i < NSEG; i++) begin
				if (flush_all) begin
					valid_reg[i] <= 1'b0;
				end else if (inval && valid_reg[i] &&
				             (in_range(base_reg[i], len_reg[i], inval_lba) ||
				              in_range(inval_lba, inval_cnt, base_reg[i]))) begin
					valid_reg[i] <= 1'b0;
				end
				if (fill && int'(fill_seg) == i) begin
					valid_reg[i] <= 1'b1;
					base_reg[i]  <= fill_lba;
					len_reg[i]   <= fill_cnt;
				end
			end
		end
	end

endmodule // dsc_seg_table

// >>> testbench/dsc_cache_ctrl_sva.sv
`timescale 1ns/1ps
// port-level checks of the cache controller
module dsc_cache_ctrl_chk (
	// clock and reset
	input wire logic                    clk,
	input wire logic                    rst_n,
	// register bus
	input wire logic                    wb_cyc_i,
	input wire logic                    wb_stb_i,
	input wire logic                    wb_we_i,
	input wire logic [7:0]              wb_adr_i,
	input wire logic [31:0]             wb_dat_o,
	input wire logic                    wb_ack_o,
	// medium and pacing
	input wire dsc_pkg::dsc_media_req_s media_req,
	input wire logic                    media_valid,
	input wire logic                    ratio_pacing,
	input wire logic                    host_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic taken;
	// request accepted at this edge
	assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
	sequence s_idle3; !host_busy [*3]; endsequence
	sequence s_size_rd; taken && !wb_we_i && wb_adr_i == dsc_pkg::OFS_SEGSIZE; endsequence
	AST_ACK_DUE: assert property (taken |=> wb_ack_o)
		else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(taken))
		else $error("ack without request");
	AST_SIZE_FFFF: assert property (s_size_rd |=> wb_dat_o[15:0] == dsc_pkg::SEGSIZE_RPT)
		else $error("segment size not reported as all ones");
	AST_MEDIA_PULSE: assert property (media_valid |=> !media_valid)
		else $error("medium launch longer than one cycle");
	AST_MEDIA_HOLD: assert property (!media_valid |-> $stable(media_req))
		else $error("medium request changed without launch");
	AST_MEDIA_BUSY: assert property (media_valid |-> host_busy)
		else $error("medium launch while idle");
	AST_PACE_IDLE: assert property (s_idle3 |-> $stable(ratio_pacing))
		else $error("pacing moved while idle");
endmodule // dsc_cache_ctrl_chk

bind dsc_cache_ctrl dsc_cache_ctrl_chk u_chk (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .media_req(media_req), .media_valid(media_valid),
	.ratio_pacing(ratio_pacing), .host_busy(host_busy));

// >>> testbench/dsc_media_model.sv
`timescale 1ns/1ps
// behavioural read/write channel: finishes each request after a set delay
module dsc_media_model (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// request side
	input wire logic       media_valid,
	input wire logic [7:0] delay,
	input wire logic       fail,
	// answer side
	output logic           media_done,
	output logic           media_err
);
	logic [7:0] wait_reg;
	// one request at a time; err toggles outside done so a stale level never looks valid
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg   <= 8'h00;
			media_done <= 1'b0;
			media_err  <= 1'b0;
		end else begin
			media_done <= (wait_reg == 8'h01);
			media_err  <= (wait_reg == 8'h01) ? fail : ~media_err;
			if (media_valid)
				wait_reg <= delay;
			else if (wait_reg != 8'h00)
				wait_reg <= wait_reg - 8'h01;
		end
	end
endmodule // dsc_media_model

// >>> testbench/dsc_cache_ctrl_bench.sv
`timescale 1ns/1ps
// self-checking run of the cache controller against a behavioural channel
module dsc_cache_ctrl_bench;
	logic                    clk, rst_n, cyc, stb, we, ack, mvalid, mdone, merr, pacing, busy, fail;
	logic [7:0]              adr, dly;
	logic [31:0]             dat, rdata, rd;
	dsc_pkg::dsc_media_req_s mreq, last_req;
	int                      fail_count, total_checks, nreq, n, r;
	int                      segs[4] = '{1, 2, 5, 16};

	dsc_cache_ctrl #(.READY_CYC(50), .ACCEPT_CYC(10)) u_dsc_cache_ctrl (.clk(clk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
		.wb_dat_i(dat), .wb_dat_o(rdata), .wb_ack_o(ack), .media_req(mreq), .media_valid(mvalid),
		.media_done(mdone), .media_err(merr), .ratio_pacing(pacing), .host_busy(busy));
	dsc_media_model u_dsc_media_model (.clk(clk), .rst_n(rst_n), .media_valid(mvalid),
		.delay(dly), .fail(fail), .media_done(mdone), .media_err(merr));

	// free-running 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// log medium launches away from the active edge
	always @(negedge clk) begin
		if (mvalid === 1'b1) begin
			nreq++;
			last_req = mreq;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic bus cycle; the request holds until ack is sampled
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 64);
		rd = rdata;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 64) chk(32'h0, 32'h1);
	endtask
	// load a command, wait for the engine to go idle, then fetch status
	task automatic run(input logic [31:0] lba, input logic [31:0] cnt, input logic [2:0] op);
		int k = 0;
		xfer(1'b1, dsc_pkg::OFS_READ_REQ, lba);
		xfer(1'b1, dsc_pkg::OFS_XFER, cnt);
		xfer(1'b1, dsc_pkg::OFS_COMMAND, {29'h0, op});
		repeat (2) @(posedge clk);
		while (busy !== 1'b0 && k < 500) begin
			@(posedge clk);
			k++;
		end
		if (k >= 500) chk(32'h0, 32'h1);
		xfer(1'b0, dsc_pkg::OFS_STATUS, 32'h0);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// bounds a hang; the whole sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		summarize();
	end
	// main sequence
	initial begin
		{rst_n, cyc, stb, we, adr, dat, fail} = '0;
		dly = 8'h03;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		xfer(1'b0, dsc_pkg::OFS_STATUS, 32'h0);
		chk({30'h0, rd[7:6]}, 32'h1);
		xfer(1'b0, dsc_pkg::OFS_CACHE_CTRL, 32'h0);
		chk({27'h0, rd[20:16]}, 32'h3);
		xfer(1'b0, dsc_pkg::OFS_PREFETCH, 32'h0);
		chk({16'h0, rd[15:0]}, 32'h0010);
		do begin
			xfer(1'b0, dsc_pkg::OFS_STATUS, 32'h0);
			n++;
		end while (rd[7:6] !== 2'h2 && n < 40);
		chk({30'h0, rd[7:6]}, 32'h2);
		chk({31'h0, rd[8]}, 32'h1);
		// sweep segment counts; size follows the count only
		foreach (segs[i]) begin
			xfer(1'b1, dsc_pkg::OFS_CACHE_CTRL, {11'h0, 5'(segs[i]), 16'h0020});
			xfer(1'b0, dsc_pkg::OFS_SEGSIZE, 32'h0);
			chk(rd, {dsc_pkg::BUF_SECTORS / 16'(segs[i]), 16'hFFFF});
		end
		xfer(1'b1, dsc_pkg::OFS_CACHE_CTRL, 32'h0000_0020);
		xfer(1'b0, dsc_pkg::OFS_SEGSIZE, 32'h0);
		chk(rd, {dsc_pkg::BUF_SECTORS / 16'h0010, 16'hFFFF});
		xfer(1'b1, dsc_pkg::OFS_CACHE_CTRL, 32'h0003_0220);
		xfer(1'b1, dsc_pkg::OFS_SEGSIZE, 32'h1234_0040);
		xfer(1'b0, dsc_pkg::OFS_SEGSIZE, 32'h0);
		chk(rd, {dsc_pkg::BUF_SECTORS / 16'h0003, 16'hFFFF});
		xfer(1'b0, dsc_pkg::OFS_STATUS, 32'h0);
		chk({31'h0, rd[4]}, 32'h1);
		// miss, full hit, partial hit
		run(32'd100, 32'd4, dsc_pkg::CMD_READ);
		chk(32'(last_req), 32'({1'b0, 32'd100, 16'd4}));
		chk({31'h0, rd[0]}, 32'h1);
		r = nreq;
		run(32'd100, 32'd4, dsc_pkg::CMD_READ);
		chk(nreq, r);
		chk({31'h0, rd[0]}, 32'h0);
		run(32'd102, 32'd4, dsc_pkg::CMD_READ);
		chk(32'(last_req), 32'({1'b0, 32'd104, 16'd2}));
		// cache disabled goes to the medium
		xfer(1'b1, dsc_pkg::OFS_CACHE_CTRL, 32'h0003_0021);
		r = nreq;
		run(32'd100, 32'd2, dsc_pkg::CMD_READ);
		chk(nreq, r + 1);
		chk({31'h0, rd[9]}, 32'h1);
		// cached write, slow channel, then flush and read back
		xfer(1'b1, dsc_pkg::OFS_CACHE_CTRL, 32'h0003_0120);
		dly <= 8'h20;
		run(32'd300, 32'd2, dsc_pkg::CMD_WRITE);
		run(32'd0, 32'd0, dsc_pkg::CMD_FLUSH);
		chk(32'(last_req), 32'({1'b1, 32'd300, 16'd2}));
		chk({31'h0, rd[2]}, 32'h1);
		r = nreq;
		run(32'd300, 32'd2, dsc_pkg::CMD_READ);
		chk(nreq, r);
		// medium failure after early good status
		fail <= 1'b1;
		run(32'd200, 32'd2, dsc_pkg::CMD_WRITE);
		chk({31'h0, rd[3]}, 32'h1);
		chk({31'h0, rd[5]}, 32'h1);
		// prefetch stops at cylinder end
		xfer(1'b1, dsc_pkg::OFS_CACHE_CTRL, 32'h0003_0000);
		xfer(1'b1, dsc_pkg::OFS_PREFETCH, 32'h0004_0008);
		xfer(1'b1, dsc_pkg::OFS_CYL_LEN, 32'h0000_0136);
		run(32'd302, 32'd2, dsc_pkg::CMD_READ);
		chk(32'(last_req), {16'd304, 16'd6});
		// stop, then start by command
		xfer(1'b1, dsc_pkg::OFS_COMMAND, {29'h0, dsc_pkg::CMD_STOP});
		xfer(1'b0, dsc_pkg::OFS_STATUS, 32'h0);
		chk({30'h0, rd[7:6]}, 32'h0);
		xfer(1'b1, dsc_pkg::OFS_COMMAND, {29'h0, dsc_pkg::CMD_START});
		n = 0;
		do begin
			xfer(1'b0, dsc_pkg::OFS_STATUS, 32'h0);
			n++;
		end while (rd[7:6] !== 2'h2 && n < 40);
		chk({30'h0, rd[7:6]}, 32'h2);
		summarize();
	end
endmodule // dsc_cache_ctrl_bench
